/* verilog/cff_pkg.sv */
// Shared constants and types for the clocked FIFO flag block, plus its input synchroniser
package cff_pkg;
    // ---------------------------------------------------------------
    // Data and flag thresholds
    // ---------------------------------------------------------------
    localparam int DATA_W = 9;
    localparam int DEPTH_DEFAULT = 512;
    localparam int ALMOST_EMPTY_LIMIT = 16;
    localparam int ALMOST_FULL_SLACK = 16;

    // ---------------------------------------------------------------
    // Flag codes as {flag_code_hi, flag_code_lo}
    // ---------------------------------------------------------------
    localparam logic [1:0] CODE_EMPTY = 2'h0;
    localparam logic [1:0] CODE_ALMOST_EMPTY = 2'h2;
    localparam logic [1:0] CODE_INTER = 2'h3;
    localparam logic [1:0] CODE_ALMOST_FULL = 2'h1;

    // Read-side view, Gray along empty -> almost empty -> intermediate
    typedef enum logic [1:0] {
        ST_EMPTY = 2'b00,
        ST_ALMOST_EMPTY = 2'b01,
        ST_INTER = 2'b11
    } cff_rd_state_t;

    // ---------------------------------------------------------------
    // Register map (byte addresses) and fields
    // ---------------------------------------------------------------
    localparam logic [11:0] OFS_STATUS = 12'h000;
    localparam logic [11:0] OFS_MASK = 12'h004;
    localparam logic [11:0] OFS_LEVEL = 12'h008;
    localparam int EV_W = 3;
    localparam int EV_OVERFLOW = 0;
    localparam int EV_ALMOST_FULL_RISE = 1;
    localparam int EV_LEFT_EMPTY = 2;
    localparam logic [EV_W-1:0] MASK_RESET = 3'h0;
    localparam int LEVEL_CODE_POS = 16;
    localparam int SYNC_STAGES = 2;

    // Pins from the writer and reader logic, synchronised as one bundle
    typedef struct packed {
        logic write_clock;
        logic write_enable_n;
        logic [DATA_W-1:0] write_data;
        logic read_clock;
        logic read_enable_n;
    } cff_pins_t;

    // APB request bundle
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } cff_apb_req_t;
endpackage : cff_pkg

`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser for a bundle of asynchronous levels
module cff_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    import cff_pkg::*;
    logic [W-1:0] meta_r;
    logic [W-1:0] q_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            q_r <= '0;
        end else begin
            meta_r <= d;
            q_r <= meta_r;
        end
    end

    assign q = q_r;
endmodule : cff_sync
`default_nettype wire

/* verilog/cff_top.sv */
// Clocked FIFO with latent flag-update cycles, sampled pins and an APB status port
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module cff_top #(
    parameter int DEPTH = cff_pkg::DEPTH_DEFAULT
) (
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    input wire logic WRITE_CLOCK,
    input wire logic WRITE_ENABLE_N,
    input wire logic [cff_pkg::DATA_W-1:0] WRITE_DATA,
    input wire logic READ_CLOCK,
    input wire logic READ_ENABLE_N,
    output logic [cff_pkg::DATA_W-1:0] READ_DATA,
    output logic FLAG_CODE_HI,
    output logic FLAG_CODE_LO,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic IRQ
);
    import cff_pkg::*;
    localparam int CW = $clog2(DEPTH + 1);
    localparam int AW = $clog2(DEPTH);
    localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
    localparam logic [CW-1:0] EMPTY_LIM_C = CW'(ALMOST_EMPTY_LIMIT);
    localparam logic [CW-1:0] FULL_SLACK_C = CW'(ALMOST_FULL_SLACK);

    // ---------------------------------------------------------------
    // Pin sampling and edge detection
    // ---------------------------------------------------------------
    cff_pins_t pins_raw;
    cff_pins_t pins_s;
    logic wclk_d_r, rclk_d_r;
    logic wr_edge, rd_edge;

    assign pins_raw = '{write_clock: WRITE_CLOCK, write_enable_n: WRITE_ENABLE_N,
                        write_data: WRITE_DATA, read_clock: READ_CLOCK,
                        read_enable_n: READ_ENABLE_N};

    // Enables and data share the clocks' latency, so they line up at each edge
    cff_sync #(.W($bits(cff_pins_t))) u_sync (
        .clk(CLK_SYS),
        .rst_n(RESET_N),
        .d(pins_raw),
        .q(pins_s)
    );

    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            wclk_d_r <= 1'b0;
            rclk_d_r <= 1'b0;
        end else begin
            wclk_d_r <= pins_s.write_clock;
            rclk_d_r <= pins_s.read_clock;
        end
    end

    assign wr_edge = pins_s.write_clock & ~wclk_d_r;
    assign rd_edge = pins_s.read_clock & ~rclk_d_r;

    // ---------------------------------------------------------------
    // Storage, count and flag views
    // ---------------------------------------------------------------
    logic [DATA_W-1:0] mem [DEPTH];
    logic [AW-1:0] wptr_r, wptr_nxt, rptr_r, rptr_nxt;
    logic [CW-1:0] count_r, count_nxt, cnt_wr, cnt_rd;
    cff_rd_state_t rd_state_r, rd_state_nxt;
    logic almost_full_r, almost_full_nxt;
    logic [1:0] code_r, code_nxt;
    logic [DATA_W-1:0] rdata_r, rdata_nxt;
    logic push, pop, overflow;

    function automatic cff_rd_state_t classify(input logic [CW-1:0] c);
        if (c == '0) begin
            return ST_EMPTY;
        end else if (c <= EMPTY_LIM_C) begin
            return ST_ALMOST_EMPTY;
        end
        return ST_INTER;
    endfunction : classify

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : bump

    always_comb begin
        overflow = wr_edge && !pins_s.write_enable_n && (count_r == DEPTH_C);
        push = wr_edge && !pins_s.write_enable_n && (count_r != DEPTH_C);
        // An empty view never pops: that edge is the latent update only
        pop = rd_edge && !pins_s.read_enable_n && (rd_state_r != ST_EMPTY)
              && (count_r != '0);
        // Each side classifies only what it saw itself; the opposite edge waits
        cnt_wr = count_r + CW'(push);
        cnt_rd = count_r - CW'(pop);
        count_nxt = count_r + CW'(push) - CW'(pop);
        wptr_nxt = push ? bump(wptr_r) : wptr_r;
        rptr_nxt = pop ? bump(rptr_r) : rptr_r;
        rdata_nxt = pop ? mem[rptr_r] : rdata_r;
        rd_state_nxt = rd_state_r;
        if (rd_edge) begin
            rd_state_nxt = classify(cnt_rd);
        end
        almost_full_nxt = almost_full_r;
        if (wr_edge) begin
            almost_full_nxt = (DEPTH_C - cnt_wr) <= FULL_SLACK_C;
        end
        // Empty-side views outrank almost full in the shared two-bit code
        case (rd_state_nxt)
            ST_EMPTY: code_nxt = CODE_EMPTY;
            ST_ALMOST_EMPTY: code_nxt = CODE_ALMOST_EMPTY;
            ST_INTER: code_nxt = almost_full_nxt ? CODE_ALMOST_FULL : CODE_INTER;
            default: code_nxt = CODE_EMPTY;
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (push) begin
            mem[wptr_r] <= pins_s.write_data;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            wptr_r <= '0;
            rptr_r <= '0;
            count_r <= '0;
            rd_state_r <= ST_EMPTY;
            almost_full_r <= 1'b0;
            code_r <= CODE_EMPTY;
            rdata_r <= '0;
        end else begin
            wptr_r <= wptr_nxt;
            rptr_r <= rptr_nxt;
            count_r <= count_nxt;
            rd_state_r <= rd_state_nxt;
            almost_full_r <= almost_full_nxt;
            code_r <= code_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign READ_DATA = rdata_r;
    assign FLAG_CODE_HI = code_r[1];
    assign FLAG_CODE_LO = code_r[0];

    // ---------------------------------------------------------------
    // APB slave, events and interrupt
    // ---------------------------------------------------------------
    cff_apb_req_t req;
    logic [EV_W-1:0] status_r, status_nxt, mask_r, mask_nxt, events;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt, pslverr_r, pslverr_nxt, irq_r, irq_nxt;
    logic access, mapped;

    assign req = '{psel: PSEL, penable: PENABLE, pwrite: PWRITE, paddr: PADDR,
                   pwdata: PWDATA};

    always_comb begin
        events = '0;
        events[EV_OVERFLOW] = overflow;
        events[EV_ALMOST_FULL_RISE] = almost_full_nxt && !almost_full_r;
        events[EV_LEFT_EMPTY] = (rd_state_r == ST_EMPTY) && (rd_state_nxt != ST_EMPTY);
        // One wait state: the answer comes on the second access cycle
        access = req.psel && req.penable && !pready_r;
        mapped = (req.paddr == OFS_STATUS) || (req.paddr == OFS_MASK)
                 || (req.paddr == OFS_LEVEL);
        pready_nxt = access;
        pslverr_nxt = access && !mapped;
        prdata_nxt = '0;
        mask_nxt = mask_r;
        // A new event wins over a same-cycle write-one-to-clear
        status_nxt = status_r;
        if (access && req.pwrite && (req.paddr == OFS_STATUS)) begin
            status_nxt = status_r & ~req.pwdata[EV_W-1:0];
        end
        status_nxt = status_nxt | events;
        if (access && req.pwrite && (req.paddr == OFS_MASK)) begin
            mask_nxt = req.pwdata[EV_W-1:0];
        end
        if (access && !req.pwrite) begin
            case (req.paddr)
                OFS_STATUS: prdata_nxt = 32'(status_r);
                OFS_MASK: prdata_nxt = 32'(mask_r);
                OFS_LEVEL: prdata_nxt = 32'(count_r) | (32'(code_r) << LEVEL_CODE_POS);
                default: prdata_nxt = '0;
            endcase
        end
        irq_nxt = |(status_nxt & mask_nxt);
    end

    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            status_r <= '0;
            mask_r <= MASK_RESET;
            prdata_r <= '0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            status_r <= status_nxt;
            mask_r <= mask_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign PRDATA = prdata_r;
    assign PREADY = pready_r;
    assign PSLVERR = pslverr_r;
    assign IRQ = irq_r;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESET_N);

    property p_latent_keeps_count;
        rd_edge && (rd_state_r == ST_EMPTY) && !wr_edge |=> count_r == $past(count_r);
    endproperty
    a_latent_keeps_count: assert property (p_latent_keeps_count)
        else $error("latent read edge changed the count");

    property p_empty_updates;
        rd_edge && (rd_state_r == ST_EMPTY) && (count_r != '0) |=> code_r != CODE_EMPTY;
    endproperty
    a_empty_updates: assert property (p_empty_updates)
        else $error("read edge did not leave empty");

    property p_writes_hold_empty;
        (rd_state_r == ST_EMPTY) && !rd_edge |=> code_r == CODE_EMPTY;
    endproperty
    a_writes_hold_empty: assert property (p_writes_hold_empty)
        else $error("empty code changed without a read edge");

    property p_last_word;
        rd_edge && !pins_s.read_enable_n && (rd_state_r == ST_ALMOST_EMPTY)
        && (count_r == CW'(1)) && !wr_edge |=> (code_r == CODE_EMPTY) && (count_r == '0);
    endproperty
    a_last_word: assert property (p_last_word)
        else $error("last read did not return to empty");

    property p_almost_empty_held;
        (rd_state_r == ST_ALMOST_EMPTY) && !rd_edge |=> rd_state_r == ST_ALMOST_EMPTY;
    endproperty
    a_almost_empty_held: assert property (p_almost_empty_held)
        else $error("almost empty changed without a read edge");

    property p_almost_empty_range;
        rd_edge && (cnt_rd >= CW'(1)) && (cnt_rd <= EMPTY_LIM_C) |=> rd_state_r == ST_ALMOST_EMPTY;
    endproperty
    a_almost_empty_range: assert property (p_almost_empty_range)
        else $error("almost empty threshold wrong");

    property p_disabled_flag_only;
        rd_edge && pins_s.read_enable_n |=> $stable(rptr_r) && $stable(READ_DATA);
    endproperty
    a_disabled_flag_only: assert property (p_disabled_flag_only)
        else $error("disabled read edge moved data");

    property p_almost_full_write_only;
        !wr_edge |=> $stable(almost_full_r);
    endproperty
    a_almost_full_write_only: assert property (p_almost_full_write_only)
        else $error("almost full changed off a write edge");

    property p_almost_full_level;
        wr_edge && ((DEPTH_C - cnt_wr) <= FULL_SLACK_C) |=> almost_full_r;
    endproperty
    a_almost_full_level: assert property (p_almost_full_level)
        else $error("almost full not set at 16 free");
endmodule : cff_top
`default_nettype wire

/* sim/cff_pins_model.sv */
// Writer and reader logic that drive the FIFO pins from the system clock
`timescale 1ns/1ps
`default_nettype none
module cff_pins_model (
    input wire logic clk,
    output logic wclk,
    output logic wen_n,
    output logic [cff_pkg::DATA_W-1:0] wdata,
    output logic rclk,
    output logic ren_n
);
    import cff_pkg::*;
    // Pin clocks start low so the release of reset shows no false edge
    initial begin
        wclk = 1'b0;
        rclk = 1'b0;
        wen_n = 1'b1;
        ren_n = 1'b1;
        wdata = '0;
    end
    // ---------------------------------------------------------------
    // One pin clock pulse; set-up, high and hold phases last three system cycles, the release four
    // ---------------------------------------------------------------
    // Enable and data are held well past the rise, the synchroniser needs two cycles
    task automatic pulse_w(input logic en_n, input logic [DATA_W-1:0] d);
        {wen_n, wdata} <= {en_n, d};
        repeat (3) @(posedge clk);
        wclk <= 1'b1;
        repeat (3) @(posedge clk);
        wclk <= 1'b0;
        repeat (3) @(posedge clk);
        // Released data lines show the inverse of the last word
        {wen_n, wdata} <= {1'b1, ~d};
        repeat (4) @(posedge clk);
    endtask : pulse_w
    task automatic pulse_r(input logic en_n);
        ren_n <= en_n;
        repeat (3) @(posedge clk);
        rclk <= 1'b1;
        repeat (3) @(posedge clk);
        rclk <= 1'b0;
        repeat (3) @(posedge clk);
        ren_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask : pulse_r
endmodule : cff_pins_model
`default_nettype wire

/* sim/tb_cff_top.sv */
// Self-checking bench for the clocked FIFO flag block
`timescale 1ns/1ps
`default_nettype none
module tb_cff_top;
    import cff_pkg::*;
    // Shallow array keeps the run short; thresholds must not move with it
    localparam int DEPTH = 64;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wclk, wen_n, rclk, ren_n, f_hi, f_lo, pready, pslverr, irq, err;
    logic [DATA_W-1:0] wdata, q;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    int fail_count = 0;
    int n_tests = 0;
    int cyc = 0;
    int wn = 0;
    int rn = 0;
    always #12.5 clk = ~clk;
    cff_pins_model u_pins (.clk(clk), .wclk(wclk), .wen_n(wen_n), .wdata(wdata),
        .rclk(rclk), .ren_n(ren_n));
    cff_top #(.DEPTH(DEPTH)) u_dut (.CLK_SYS(clk), .RESET_N(rst_n), .WRITE_CLOCK(wclk),
        .WRITE_ENABLE_N(wen_n), .WRITE_DATA(wdata), .READ_CLOCK(rclk),
        .READ_ENABLE_N(ren_n), .READ_DATA(q), .FLAG_CODE_HI(f_hi), .FLAG_CODE_LO(f_lo),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq));
    // ---------------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------------
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // Request held until the edge where pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
        @(posedge clk);
    endtask : apb
    task automatic chkf(input logic [1:0] c);
        chk({30'h0, f_hi, f_lo}, {30'h0, c});
    endtask : chkf
    task automatic lvl(input int cnt, input logic [1:0] c);
        apb(1'b0, OFS_LEVEL, 32'h0000_0000);
        chk(rd, {14'h0, c, 16'(cnt)});
    endtask : lvl
    task automatic w(input int n);
        for (int i = 0; i < n; i++) begin
            u_pins.pulse_w(1'b0, DATA_W'(wn));
            wn++;
        end
    endtask : w
    task automatic r(input logic en_n);
        u_pins.pulse_r(en_n);
        if (en_n == 1'b0) begin
            chk({23'h0, q}, 32'(DATA_W'(rn)));
            rn++;
        end
    endtask : r
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 12000) begin
            fail_count++;
            wrap_up();
        end
    end
    // ---------------------------------------------------------------
    // Test sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        lvl(0, CODE_EMPTY);
        chk({31'h0, irq}, 32'h0);
        w(2);
        chkf(CODE_EMPTY);
        lvl(2, CODE_EMPTY);
        r(1'b1);
        chkf(CODE_ALMOST_EMPTY);
        lvl(2, CODE_ALMOST_EMPTY);
        r(1'b0);
        r(1'b0);
        chkf(CODE_EMPTY);
        lvl(0, CODE_EMPTY);
        apb(1'b0, OFS_STATUS, 32'h0000_0000);
        chk(rd & 32'h0000_0004, 32'h0000_0004);
        $display("test 1 finished");
        w(16);
        r(1'b1);
        chkf(CODE_ALMOST_EMPTY);
        w(2);
        chkf(CODE_ALMOST_EMPTY);
        r(1'b0);
        lvl(17, CODE_INTER);
        r(1'b0);
        r(1'b1);
        lvl(16, CODE_ALMOST_EMPTY);
        $display("test 2 finished");
        apb(1'b1, OFS_MASK, 32'h0000_0002);
        apb(1'b0, OFS_MASK, 32'h0000_0000);
        chk(rd, 32'h0000_0002);
        w(30);
        r(1'b1);
        lvl(46, CODE_INTER);
        w(1);
        chkf(CODE_INTER);
        chk({31'h0, irq}, 32'h0);
        w(1);
        chkf(CODE_ALMOST_FULL);
        chk({31'h0, irq}, 32'h1);
        apb(1'b0, OFS_STATUS, 32'h0000_0000);
        chk(rd & 32'h0000_0002, 32'h0000_0002);
        apb(1'b1, OFS_STATUS, 32'h0000_0002);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        r(1'b0);
        r(1'b0);
        chkf(CODE_ALMOST_FULL);
        u_pins.pulse_w(1'b1, 9'h055);
        lvl(46, CODE_INTER);
        $display("test 3 finished");
        w(18);
        u_pins.pulse_w(1'b0, 9'h1aa);
        lvl(64, CODE_ALMOST_FULL);
        apb(1'b0, OFS_STATUS, 32'h0000_0000);
        chk(rd & 32'h0000_0001, 32'h0000_0001);
        apb(1'b0, 12'h00c, 32'h0000_0000);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0000_0000);
        apb(1'b1, 12'h00c, 32'h0000_0007);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, OFS_MASK, 32'h0000_0000);
        chk(rd, 32'h0000_0002);
        for (int i = 0; i < 64; i++) begin
            r(1'b0);
        end
        chkf(CODE_EMPTY);
        $display("test 4 finished");
        wrap_up();
    end
endmodule : tb_cff_top
`default_nettype wire
